// ### core/rtcc_pkg.sv
/*
  Shared constants of the calendar counter chain: register byte
  addresses, field masks, control bits, BCD limits and timing.
  Assumes a single 40 MHz system clock and a 32-bit AHB-Lite bus.
*/
package rtcc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned DIV_BASE_HZ = 128; // twice the 64 Hz tap
  localparam int unsigned TICK_CYCLES = CLK_HZ / DIV_BASE_HZ;
  localparam int TICK_W = 19;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DIV = 8'h00;
  localparam logic [7:0] ADDR_SEC = 8'h04;
  localparam logic [7:0] ADDR_MIN = 8'h08;
  localparam logic [7:0] ADDR_HOUR = 8'h0c;
  localparam logic [7:0] ADDR_WDAY = 8'h10;
  localparam logic [7:0] ADDR_DATE = 8'h14;
  localparam logic [7:0] ADDR_MONTH = 8'h18;
  localparam logic [7:0] ADDR_YEAR = 8'h1c;
  localparam logic [7:0] ADDR_CTRL = 8'h20;

  // ----------------------------------------------------------------
  // implemented bits of each register, others read zero
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_DIV = 8'h7f;
  localparam logic [7:0] MASK_SEC = 8'h7f;
  localparam logic [7:0] MASK_MIN = 8'h7f;
  localparam logic [7:0] MASK_HOUR = 8'h3f;
  localparam logic [7:0] MASK_WDAY = 8'h07;
  localparam logic [7:0] MASK_DATE = 8'h3f;
  localparam logic [7:0] MASK_MONTH = 8'h1f;
  localparam logic [7:0] MASK_YEAR = 8'hff;

  // ----------------------------------------------------------------
  // control register bits
  // ----------------------------------------------------------------
  localparam int CTRL_START = 0;
  localparam int CTRL_RESET = 1;
  localparam int CTRL_ADJ = 2;
  localparam logic CTRL_START_RST = 1'b0;

  // ----------------------------------------------------------------
  // counter limits (BCD; DIV_FULL is binary)
  // ----------------------------------------------------------------
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] BCD_HALF_MIN = 8'h30;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] MONTH_FEB = 8'h02;
  localparam logic [7:0] MONTH_APR = 8'h04;
  localparam logic [7:0] MONTH_JUN = 8'h06;
  localparam logic [7:0] MONTH_SEP = 8'h09;
  localparam logic [7:0] MONTH_NOV = 8'h11;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;
  localparam logic [2:0] WDAY_MAX = 3'h6;
  localparam logic [6:0] DIV_FULL = 7'h7f;
  localparam logic [3:0] BCD_NINE = 4'h9;

  // ----------------------------------------------------------------
  // bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage

// ### core/rtcc_bcd_cnt.sv
/*
  Two-digit BCD counter with load, wrap and carry.
  Assumes in-range BCD values from software; holds no reset so the
  count survives system resets.
*/
`timescale 1ns/1ps
module rtcc_bcd_cnt import rtcc_pkg::*; (
  input wire logic mclk,
  input wire logic inc,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] mask,
  input wire logic [7:0] min_val,
  input wire logic [7:0] max_val,
  output logic [7:0] count,
  output logic carry
);

  logic [7:0] count_reg;
  logic [7:0] count_next;

  // ------------------------------------------------------------------
  // next count: load wins over increment
  // ------------------------------------------------------------------
  always_comb begin
    count_next = count_reg;
    if (wr_en) begin
      count_next = wr_data & mask;
    end else if (inc) begin
      if (count_reg == max_val) begin
        count_next = min_val;
      end else if (count_reg[3:0] == BCD_NINE) begin
        count_next = {count_reg[7:4] + 4'h1, 4'h0};
      end else begin
        count_next = {count_reg[7:4], count_reg[3:0] + 4'h1};
      end
    end
  end

  // no reset: the count is kept through every reset
  always_ff @(posedge mclk) begin
    count_reg <= count_next;
  end

  assign count = count_reg;
  assign carry = inc && !wr_en && (count_reg == max_val);

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  chk_wrap_min: assert property (@(posedge mclk)
    inc && !wr_en && count_reg == max_val |=> count_reg == $past(min_val))
    else $error("counter did not wrap to its low bound");

  chk_unused_zero: assert property (@(posedge mclk)
    wr_en |=> (count_reg & ~$past(mask)) == 8'h00)
    else $error("unimplemented counter bits not zero");

endmodule

// ### core/rtcc_top.sv
/*
  Calendar counter chain with AHB-Lite register access.
  // How it works
  // - divider reads bit7 zero, bits 6..0 are taps 64 Hz to 1 Hz
  // - setting reset or adjust bit clears the divider to zero
  // - divider and calendar counters keep values through all resets
  // - seconds count up once per divider one-second carry
  // - seconds: tens bits 6..4, units 3..0, 00..59, bit7 zero
  // - minutes step on seconds carry, 00..59, bit7 zero
  // - hours step on minutes carry, 00..23, bits 7..6 zero
  // - weekday steps daily, 0 Sunday to 6 Saturday, bits 7..3 zero
  // - date steps daily, 01..31, tens bits 5..4, bits 7..6 zero
  // - month steps on date carry, tens in bit4, bits 7..5 zero
  // - month carry steps year; year divisible by four is leap
  Assumes one 40 MHz clock, a single AHB-Lite master and zero waits.
*/
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module rtcc_top import rtcc_pkg::*; #(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  // ------------------------------------------------------------------
  // bus address phase capture
  // ------------------------------------------------------------------
  logic wr_pend_reg;
  logic wr_pend_next;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_addr_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic addr_take;
  logic [7:0] rd_mux;

  // ------------------------------------------------------------------
  // control and divider state
  // ------------------------------------------------------------------
  logic start_reg;
  logic start_next;
  logic [TICK_W-1:0] pre_reg;
  logic [TICK_W-1:0] pre_next;
  logic [6:0] div_reg;
  logic [6:0] div_next;
  logic [2:0] wday_reg;
  logic [2:0] wday_next;
  logic tick;
  logic div_clr;
  logic thirty_second_adjust_bit;
  logic sec_tick;

  // ------------------------------------------------------------------
  // counter chain wires
  // ------------------------------------------------------------------
  logic wr_sec;
  logic wr_min;
  logic wr_hour;
  logic wr_wday;
  logic wr_date;
  logic wr_month;
  logic wr_year;
  logic [7:0] wdata8;
  logic [7:0] sec_wdata;
  logic [7:0] sec_q;
  logic [7:0] min_q;
  logic [7:0] hour_q;
  logic [7:0] date_q;
  logic [7:0] month_q;
  logic [7:0] year_q;
  logic sec_carry;
  logic min_inc;
  logic min_carry;
  logic hour_carry;
  logic date_carry;
  logic month_carry;
  logic leap;
  logic [7:0] days_in_month;
  logic ctrl_wr;

  assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_reg;
  assign wdata8 = hwdata[7:0];

  // data-phase write strobes per register
  assign ctrl_wr = wr_pend_reg && (wr_addr_reg == ADDR_CTRL);
  assign wr_min = wr_pend_reg && (wr_addr_reg == ADDR_MIN);
  assign wr_hour = wr_pend_reg && (wr_addr_reg == ADDR_HOUR);
  assign wr_wday = wr_pend_reg && (wr_addr_reg == ADDR_WDAY);
  assign wr_date = wr_pend_reg && (wr_addr_reg == ADDR_DATE);
  assign wr_month = wr_pend_reg && (wr_addr_reg == ADDR_MONTH);
  assign wr_year = wr_pend_reg && (wr_addr_reg == ADDR_YEAR);

  // reset and adjust are write-one actions, never stored
  assign div_clr = ctrl_wr && (hwdata[CTRL_RESET] || hwdata[CTRL_ADJ]);
  assign thirty_second_adjust_bit = ctrl_wr && hwdata[CTRL_ADJ];

  // ------------------------------------------------------------------
  // read mux, unmapped addresses read zero
  // ------------------------------------------------------------------
  always_comb begin
    case (haddr[7:0])
      ADDR_DIV: rd_mux = {1'b0, div_reg};
      ADDR_SEC: rd_mux = sec_q;
      ADDR_MIN: rd_mux = min_q;
      ADDR_HOUR: rd_mux = hour_q;
      ADDR_WDAY: rd_mux = {5'h00, wday_reg};
      ADDR_DATE: rd_mux = date_q;
      ADDR_MONTH: rd_mux = month_q;
      ADDR_YEAR: rd_mux = year_q;
      ADDR_CTRL: rd_mux = {7'h00, start_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  // bus next state
  always_comb begin
    wr_pend_next = addr_take && hwrite;
    wr_addr_next = addr_take ? haddr[7:0] : wr_addr_reg;
    hrdata_next = hrdata_reg;
    if (addr_take && !hwrite) begin
      hrdata_next = {24'h000000, rd_mux};
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // ------------------------------------------------------------------
  // start bit and 128 Hz prescaler
  // ------------------------------------------------------------------
  assign tick = start_reg && (pre_reg == TICK_W'(TICK_DIV - 1));

  always_comb begin
    start_next = ctrl_wr ? hwdata[CTRL_START] : start_reg;
    pre_next = pre_reg;
    if (div_clr || !start_reg || tick) begin
      pre_next = '0;
    end else begin
      pre_next = pre_reg + TICK_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      start_reg <= CTRL_START_RST;
      pre_reg <= '0;
    end else begin
      start_reg <= start_next;
      pre_reg <= pre_next;
    end
  end

  // ------------------------------------------------------------------
  // divider taps; bit n toggles at 64 Hz >> n
  // ------------------------------------------------------------------
  assign sec_tick = tick && !div_clr && (div_reg == DIV_FULL);

  always_comb begin
    div_next = div_reg;
    if (div_clr) begin
      div_next = 7'h00;
    end else if (tick) begin
      div_next = div_reg + 7'h01;
    end
  end

  // unreset so the divider survives system resets
  always_ff @(posedge mclk) begin
    div_reg <= div_next;
  end

  // ------------------------------------------------------------------
  // seconds, with the 30-second adjust folded in
  // ------------------------------------------------------------------
  assign wr_sec = (wr_pend_reg && (wr_addr_reg == ADDR_SEC)) || thirty_second_adjust_bit;
  assign sec_wdata = thirty_second_adjust_bit ? BCD_ZERO : wdata8;
  assign min_inc = sec_carry || (thirty_second_adjust_bit && (sec_q >= BCD_HALF_MIN));

  rtcc_bcd_cnt u_sec (
    .mclk(mclk),
    .inc(sec_tick),
    .wr_en(wr_sec),
    .wr_data(sec_wdata),
    .mask(MASK_SEC),
    .min_val(BCD_ZERO),
    .max_val(SEC_MAX),
    .count(sec_q),
    .carry(sec_carry)
  );

  rtcc_bcd_cnt u_min (
    .mclk(mclk),
    .inc(min_inc),
    .wr_en(wr_min),
    .wr_data(wdata8),
    .mask(MASK_MIN),
    .min_val(BCD_ZERO),
    .max_val(SEC_MAX),
    .count(min_q),
    .carry(min_carry)
  );

  rtcc_bcd_cnt u_hour (
    .mclk(mclk),
    .inc(min_carry),
    .wr_en(wr_hour),
    .wr_data(wdata8),
    .mask(MASK_HOUR),
    .min_val(BCD_ZERO),
    .max_val(HOUR_MAX),
    .count(hour_q),
    .carry(hour_carry)
  );

  // ------------------------------------------------------------------
  // weekday, binary 0..6
  // ------------------------------------------------------------------
  always_comb begin
    wday_next = wday_reg;
    if (wr_wday) begin
      wday_next = wdata8[2:0];
    end else if (hour_carry) begin
      wday_next = (wday_reg == WDAY_MAX) ? 3'h0 : wday_reg + 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    wday_reg <= wday_next;
  end

  // ------------------------------------------------------------------
  // month length and leap year
  // ------------------------------------------------------------------
  // year is leap when tens even and units 0,4,8 or tens odd and 2,6
  always_comb begin
    if (year_q[4]) begin
      leap = (year_q[3:0] == 4'h2) || (year_q[3:0] == 4'h6);
    end else begin
      leap = (year_q[3:0] == 4'h0) || (year_q[3:0] == 4'h4) ||
             (year_q[3:0] == 4'h8);
    end
  end

  always_comb begin
    case (month_q)
      MONTH_FEB: days_in_month = leap ? DAYS_29 : DAYS_28;
      MONTH_APR: days_in_month = DAYS_30;
      MONTH_JUN: days_in_month = DAYS_30;
      MONTH_SEP: days_in_month = DAYS_30;
      MONTH_NOV: days_in_month = DAYS_30;
      default: days_in_month = DAYS_31;
    endcase
  end

  rtcc_bcd_cnt u_date (
    .mclk(mclk),
    .inc(hour_carry),
    .wr_en(wr_date),
    .wr_data(wdata8),
    .mask(MASK_DATE),
    .min_val(BCD_ONE),
    .max_val(days_in_month),
    .count(date_q),
    .carry(date_carry)
  );

  rtcc_bcd_cnt u_month (
    .mclk(mclk),
    .inc(date_carry),
    .wr_en(wr_month),
    .wr_data(wdata8),
    .mask(MASK_MONTH),
    .min_val(BCD_ONE),
    .max_val(MONTH_MAX),
    .count(month_q),
    .carry(month_carry)
  );

  rtcc_bcd_cnt u_year (
    .mclk(mclk),
    .inc(month_carry),
    .wr_en(wr_year),
    .wr_data(wdata8),
    .mask(MASK_YEAR),
    .min_val(BCD_ZERO),
    .max_val(YEAR_MAX),
    .count(year_q),
    .carry()
  );

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  chk_div_clear: assert property (@(posedge mclk) disable iff (!reset_n)
    div_clr |=> div_reg == 7'h00 && sec_q == $past(sec_q) || $past(thirty_second_adjust_bit))
    else $error("divider not cleared by reset or adjust");

  chk_sec_from_div: assert property (@(posedge mclk)
    disable iff (!reset_n)
    sec_tick && !wr_sec |=> div_reg == 7'h00 && sec_q != $past(sec_q))
    else $error("seconds did not step on divider carry");

  chk_div_halt: assert property (@(posedge mclk) disable iff (!reset_n)
    !start_reg && !div_clr |=> $stable(div_reg))
    else $error("divider moved while stopped");

  chk_min_step: assert property (@(posedge mclk) disable iff (!reset_n)
    sec_carry && !wr_min && min_q == SEC_MAX |=> min_q == BCD_ZERO)
    else $error("minutes did not wrap on seconds carry");

  chk_hour_wrap: assert property (@(posedge mclk) disable iff (!reset_n)
    min_carry && !wr_hour && hour_q == HOUR_MAX |=> hour_q == BCD_ZERO
    ##0 wday_reg != $past(wday_reg) || $past(wr_wday))
    else $error("hours did not wrap or weekday did not step");

  chk_wday_wrap: assert property (@(posedge mclk) disable iff (!reset_n)
    hour_carry && !wr_wday && wday_reg == WDAY_MAX |=> wday_reg == 3'h0)
    else $error("weekday did not wrap to Sunday");

  chk_feb_leap: assert property (@(posedge mclk) disable iff (!reset_n)
    hour_carry && !wr_date && month_q == MONTH_FEB && date_q == DAYS_28
    && leap |=> date_q == DAYS_29)
    else $error("leap February ended on the 28th");

  chk_month_wrap: assert property (@(posedge mclk) disable iff (!reset_n)
    date_carry && !wr_month && !wr_year && month_q == MONTH_MAX
    |=> month_q == BCD_ONE && year_q != $past(year_q))
    else $error("month did not wrap to 01 with year step");

endmodule

// ### sim/rtcc_top_tb.sv
/*
  Self-checking bench for the calendar counter chain: bus tasks,
  one task per scenario, and a single verdict at the end.
  Assumes rtcc_pkg, a zero-wait slave and a shortened tick divider.
*/
`timescale 1ns/1ps
module rtcc_top_tb import rtcc_pkg::*;;

  // ----------------------------------------------------------------
  // clock, reset and bus signals
  // ----------------------------------------------------------------
  localparam int unsigned TB_TICK = 4; // one second is 4*128 cycles
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  int fail_count = 0;
  int samples_checked = 0;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  rtcc_top #(.TICK_DIV(TB_TICK)) rtcc_top_i (
    .mclk(mclk),
    .reset_n(reset_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata)
  );

  // 40 MHz clock
  initial begin
    forever #12.5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  // wait for ready sampled at a rising edge; hang counts as mismatch
  task automatic wait_ready(output logic [31:0] rd);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      $display("FAIL hready expected 1 seen %b", hreadyout);
      print_verdict();
    end
    rd = hrdata;
  endtask

  task automatic bus_xfer(input logic wr, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] rd);
    logic [31:0] dummy;
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready(dummy);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready(rd);
    check("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus_xfer(1'b1, a, d, rd);
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] rd);
    bus_xfer(1'b0, a, 32'h0, rd);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // read-only bits written as ones read zero; divider read-only
  task automatic masks_and_divider;
    logic [31:0] v;
    logic [7:0] w [0:5];
    logic [7:0] e [0:5];
    w = '{8'hd9, 8'hd9, 8'he3, 8'hfe, 8'hf1, 8'hf2};
    e = '{8'h59, 8'h59, 8'h23, 8'h06, 8'h31, 8'h12};
    bus_write(ADDR_CTRL, 32'h2);
    bus_write(ADDR_DIV, 32'hff);
    bus_read(ADDR_DIV, v);
    check("divider", 32'h0, v);
    for (int i = 0; i < 6; i++) begin
      bus_write(ADDR_SEC + 8'(4 * i), {24'h0, w[i]});
      bus_read(ADDR_SEC + 8'(4 * i), v);
      check("mask", {24'h0, e[i]}, v);
    end
    bus_read(8'h40, v);
    check("unmapped", 32'h0, v);
  endtask

  // lowest tap moves first after the divider is cleared and started
  task automatic divider_taps;
    logic [31:0] v;
    int n;
    bus_write(ADDR_CTRL, 32'h3);
    n = 0;
    do begin
      bus_read(ADDR_DIV, v);
      n++;
    end while (v === 32'h0 && n < 40);
    check("divider_first", 32'h1, v);
    bus_write(ADDR_CTRL, 32'h0);
    bus_read(ADDR_CTRL, v);
    check("ctrl", 32'h0, v);
  endtask

  // load sec,min,hour,wday,date,month,year, run one second, compare
  task automatic run_row(input logic [55:0] s, input logic [55:0] e);
    logic [31:0] v;
    int n;
    bus_write(ADDR_CTRL, 32'h0);
    for (int i = 0; i < 7; i++) begin
      bus_write(ADDR_SEC + 8'(4 * i), {24'h0, s[55 - 8 * i -: 8]});
    end
    bus_write(ADDR_CTRL, 32'h3);
    n = 0;
    do begin
      bus_read(ADDR_SEC, v);
      n++;
    end while (v[7:0] === s[55:48] && n < 400);
    if (v[7:0] === s[55:48]) begin
      fail_count++;
      $display("FAIL seconds expected change seen %h", v);
      print_verdict();
    end
    bus_write(ADDR_CTRL, 32'h0);
    for (int i = 0; i < 7; i++) begin
      bus_read(ADDR_SEC + 8'(4 * i), v);
      check($sformatf("calendar_%0d", i), {24'h0, e[55 - 8 * i -: 8]}, v);
    end
  endtask

  // adjust clears seconds and divider, rounding minutes up from 30
  task automatic adjust_and_reset;
    logic [31:0] v;
    bus_write(ADDR_SEC, 32'h45);
    bus_write(ADDR_MIN, 32'h10);
    bus_write(ADDR_CTRL, 32'h4);
    bus_read(ADDR_DIV, v);
    check("divider_adj", 32'h0, v);
    bus_read(ADDR_SEC, v);
    check("sec_adj", 32'h0, v);
    bus_read(ADDR_MIN, v);
    check("min_adj", 32'h11, v);
    bus_write(ADDR_SEC, 32'h37);
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    bus_read(ADDR_SEC, v);
    check("sec_keep", 32'h37, v);
    bus_read(ADDR_MIN, v);
    check("min_keep", 32'h11, v);
    bus_read(ADDR_DIV, v);
    check("div_keep", 32'h0, v);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    masks_and_divider();
    divider_taps();
    run_row(56'h59_59_23_06_28_02_23, 56'h00_00_00_00_01_03_23);
    run_row(56'h59_59_23_02_28_02_24, 56'h00_00_00_03_29_02_24);
    run_row(56'h59_59_23_03_29_02_24, 56'h00_00_00_04_01_03_24);
    run_row(56'h59_59_23_05_31_12_99, 56'h00_00_00_06_01_01_00);
    run_row(56'h59_59_23_00_30_04_24, 56'h00_00_00_01_01_05_24);
    run_row(56'h59_09_09_01_09_01_24, 56'h00_10_09_01_09_01_24);
    run_row(56'h59_59_19_04_15_07_24, 56'h00_00_20_04_15_07_24);
    run_row(56'h08_30_10_02_11_11_24, 56'h09_30_10_02_11_11_24);
    adjust_and_reset();
    print_verdict();
  end

endmodule
